// >>> rtl/flash_host_pkg.sv
// constants shared by the flash status host controller
`default_nettype none
package flash_host_pkg;
   localparam int CLK_NS = 50;
   localparam int ADDR_W = 26;
   localparam int DATA_W = 16;
   localparam int REG_AW = 8;
   // strobe timing of the flash bus
   localparam int T_ACC_NS = 90;
   localparam int T_WP_NS = 35;
   localparam int T_PH_NS = 20;
   localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PH_CYC = (T_PH_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 4;
   // software register offsets
   localparam logic [REG_AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [REG_AW-1:0] OFF_CMD_ADDR = 8'h04;
   localparam logic [REG_AW-1:0] OFF_CMD_DATA = 8'h08;
   localparam logic [REG_AW-1:0] OFF_POLL_ADDR = 8'h0c;
   localparam logic [REG_AW-1:0] OFF_POLL_CFG = 8'h10;
   localparam logic [REG_AW-1:0] OFF_STATE = 8'h14;
   localparam logic [REG_AW-1:0] OFF_SR_WORD = 8'h18;
   localparam logic [REG_AW-1:0] OFF_POLL_WORD = 8'h1c;
   localparam logic [REG_AW-1:0] OFF_DATA_WORD = 8'h20;
   // control register fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_WAIT_READY = 3;
   localparam int CTRL_TOGGLE_DONE = 4;
   localparam logic [2:0] OP_CMD = 3'h1;
   localparam logic [2:0] OP_STATUS = 3'h2;
   localparam logic [2:0] OP_POLL = 3'h3;
   // status word bit positions
   localparam int SR_READY = 7;
   localparam int SR_ERASE_PAUSED = 6;
   localparam int SR_ERASE_RESULT = 5;
   localparam int SR_PROGRAM_RESULT = 4;
   localparam int SR_BUFFER_ABORT = 3;
   localparam int SR_PROGRAM_PAUSED = 2;
   localparam int SR_LOCKED_SECTOR = 1;
   localparam logic [DATA_W-1:0] SR_MASK = 16'h00fe;
   // polling word bit positions
   localparam int PB_POLL = 7;
   localparam int PB_TOGGLE_ONE = 6;
   localparam int PB_TIMEOUT = 5;
   localparam int PB_ERASE_TIMER = 3;
   localparam int PB_TOGGLE_TWO = 2;
   localparam int PB_ABORT = 1;
   localparam logic [DATA_W-1:0] POLL_MASK = 16'h00ee;
   // state register fields
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL_TIMEOUT = 2;
   localparam int ST_FAIL_ABORT = 3;
   localparam int ST_TB1_TOGGLED = 4;
   localparam int ST_TB2_TOGGLED = 5;
   localparam int ST_ERASE_TIMER = 6;
   localparam int ST_SR_READY = 7;
   localparam int ST_PIN_READY = 8;
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_cmd = 3'b001,
      st_sr_read = 3'b011,
      st_poll = 3'b010,
      st_final = 3'b110
   } host_state_t;
   typedef enum logic [1:0] {
      ph_idle = 2'b00,
      ph_active = 2'b01,
      ph_hold = 2'b11
   } bus_phase_t;
endpackage
`default_nettype wire

// >>> rtl/flash_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
`default_nettype none
module flash_bus_cycle (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic write,
   input wire logic [flash_host_pkg::ADDR_W-1:0] addr,
   input wire logic [flash_host_pkg::DATA_W-1:0] wdata,
   output logic done,
   output logic [flash_host_pkg::DATA_W-1:0] rdata,
   output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
   output logic [flash_host_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
   output logic chip_select_n,
   output logic output_strobe_n,
   output logic write_strobe_n
);
   import flash_host_pkg::*;
   bus_phase_t phase_reg, phase_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic cs_next, os_next, ws_next, oe_next;
   logic [ADDR_W-1:0] addr_next;
   logic [DATA_W-1:0] dout_next, rdata_next;
   wire logic cnt_zero = (cnt_reg == '0);
   wire logic launch;

   assign done = (phase_reg == ph_hold) && cnt_zero;
   assign launch = start && ((phase_reg == ph_idle) || done);

   always_comb begin
      phase_next = phase_reg;
      cnt_next = cnt_reg;
      cs_next = chip_select_n;
      os_next = output_strobe_n;
      ws_next = write_strobe_n;
      oe_next = dq_oe;
      addr_next = flash_addr;
      dout_next = dq_out;
      rdata_next = rdata;
      if (launch) begin
         phase_next = ph_active;
         cnt_next = write ? CNT_W'(WP_CYC - 1) : CNT_W'(ACC_CYC - 1);
         addr_next = addr;
         dout_next = wdata;
         oe_next = write;
         cs_next = 1'b0;
         os_next = write;
         ws_next = ~write;
      end else if (phase_reg == ph_active) begin
         if (cnt_zero) begin
            // rising strobe edges latch a command or close the read
            if (!dq_oe) begin
               rdata_next = dq_in;
            end
            cs_next = 1'b1;
            os_next = 1'b1;
            ws_next = 1'b1;
            phase_next = ph_hold;
            cnt_next = CNT_W'(PH_CYC - 1);
         end else begin
            cnt_next = cnt_reg - 1'b1;
         end
      end else if (phase_reg == ph_hold) begin
         if (cnt_zero) begin
            oe_next = 1'b0;
            phase_next = ph_idle;
         end else begin
            cnt_next = cnt_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_reg <= ph_idle;
         cnt_reg <= '0;
         chip_select_n <= 1'b1;
         output_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         dq_oe <= 1'b0;
         flash_addr <= '0;
         dq_out <= '0;
         rdata <= '0;
      end else begin
         phase_reg <= phase_next;
         cnt_reg <= cnt_next;
         chip_select_n <= cs_next;
         output_strobe_n <= os_next;
         write_strobe_n <= ws_next;
         dq_oe <= oe_next;
         flash_addr <= addr_next;
         dq_out <= dout_next;
         rdata <= rdata_next;
      end
   end
endmodule // flash_bus_cycle
`default_nettype wire

// >>> rtl/flash_status_monitor.sv
// host controller that reads flash status words and polls embedded algorithms
// Function
// - status bits 15:8 undefined; host masks them
// - ready when idle; lower bits valid then
// - after suspend, reread status until ready
// - buffered program polls last loaded address
// - erase poll bit 0, then 1; address sector
// - read true data on following read cycle
`default_nettype none
module flash_status_monitor (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [flash_host_pkg::REG_AW-1:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_write,
   input wire logic sw_read,
   output logic [31:0] sw_rdata,
   output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
   output logic [flash_host_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
   output logic chip_select_n,
   output logic output_strobe_n,
   output logic write_strobe_n,
   input wire logic ready_busy_n
);
   import flash_host_pkg::*;

   host_state_t state_reg, state_next;
   logic [2:0] op_reg, op_next;
   logic wait_ready_reg, wait_ready_next;
   logic toggle_done_reg, toggle_done_next;
   logic [ADDR_W-1:0] cmd_addr_reg, poll_addr_reg;
   logic [DATA_W-1:0] cmd_data_reg, expect_reg;
   logic [DATA_W-1:0] sr_word_reg, sr_word_next;
   logic [DATA_W-1:0] poll_word_reg, poll_word_next;
   logic [DATA_W-1:0] data_word_reg, data_word_next;
   logic first_reg, first_next;
   logic timeout_seen_reg, timeout_seen_next;
   logic done_reg, done_next;
   logic fail_timeout_reg, fail_timeout_next;
   logic fail_abort_reg, fail_abort_next;
   logic tb1_tog_reg, tb1_tog_next;
   logic tb2_tog_reg, tb2_tog_next;
   logic [31:0] sw_rdata_next;
   logic bus_start, bus_write;
   logic [ADDR_W-1:0] bus_addr;
   logic [DATA_W-1:0] bus_wdata;
   logic bus_done;
   logic [DATA_W-1:0] bus_rdata;

   // software port decode
   wire logic busy = (state_reg != st_idle);
   wire logic wr_ctrl = sw_write && (sw_addr == OFF_CTRL);
   wire logic wr_cmd_addr = sw_write && (sw_addr == OFF_CMD_ADDR);
   wire logic wr_cmd_data = sw_write && (sw_addr == OFF_CMD_DATA);
   wire logic wr_poll_addr = sw_write && (sw_addr == OFF_POLL_ADDR);
   wire logic wr_poll_cfg = sw_write && (sw_addr == OFF_POLL_CFG);
   wire logic [2:0] ctrl_op = sw_wdata[CTRL_OP_LSB +: 3];
   wire logic start_op = wr_ctrl && !busy &&
      ((ctrl_op == OP_CMD) || (ctrl_op == OP_STATUS) || (ctrl_op == OP_POLL));

   // evaluation of a polling word just read
   wire logic [DATA_W-1:0] poll_masked = bus_rdata & POLL_MASK;
   wire logic poll_match = (bus_rdata[PB_POLL] == expect_reg[PB_POLL]);
   wire logic tb1_changed = (bus_rdata[PB_TOGGLE_ONE] != poll_word_reg[PB_TOGGLE_ONE]);
   wire logic tb2_changed = (bus_rdata[PB_TOGGLE_TWO] != poll_word_reg[PB_TOGGLE_TWO]);
   wire logic toggle_stopped = toggle_done_reg && !tb1_changed;
   wire logic sr_ready_now = bus_rdata[SR_READY];

   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      wait_ready_next = wait_ready_reg;
      toggle_done_next = toggle_done_reg;
      sr_word_next = sr_word_reg;
      poll_word_next = poll_word_reg;
      data_word_next = data_word_reg;
      first_next = first_reg;
      timeout_seen_next = timeout_seen_reg;
      done_next = done_reg;
      fail_timeout_next = fail_timeout_reg;
      fail_abort_next = fail_abort_reg;
      tb1_tog_next = tb1_tog_reg;
      tb2_tog_next = tb2_tog_reg;
      bus_start = 1'b0;
      bus_write = 1'b0;
      bus_addr = poll_addr_reg;
      bus_wdata = cmd_data_reg;
      unique case (state_reg)
         st_idle: begin
            if (start_op) begin
               op_next = ctrl_op;
               wait_ready_next = sw_wdata[CTRL_WAIT_READY];
               toggle_done_next = sw_wdata[CTRL_TOGGLE_DONE];
               done_next = 1'b0;
               fail_timeout_next = 1'b0;
               fail_abort_next = 1'b0;
               tb1_tog_next = 1'b0;
               tb2_tog_next = 1'b0;
               first_next = 1'b1;
               timeout_seen_next = 1'b0;
               bus_start = 1'b1;
               if (ctrl_op == OP_POLL) begin
                  state_next = st_poll;
               end else begin
                  // command word, status-read command among them
                  bus_write = 1'b1;
                  bus_addr = cmd_addr_reg;
                  state_next = st_cmd;
               end
            end
         end
         st_cmd: begin
            if (bus_done) begin
               if (op_reg == OP_STATUS) begin
                  // one read takes the overlay word and leaves the overlay
                  bus_start = 1'b1;
                  bus_addr = cmd_addr_reg;
                  state_next = st_sr_read;
               end else begin
                  done_next = 1'b1;
                  state_next = st_idle;
               end
            end
         end
         st_sr_read: begin
            if (bus_done) begin
               sr_word_next = bus_rdata & SR_MASK;
               if (wait_ready_reg && !sr_ready_now) begin
                  // still settling after suspend: ask again
                  bus_start = 1'b1;
                  bus_write = 1'b1;
                  bus_addr = cmd_addr_reg;
                  state_next = st_cmd;
               end else begin
                  done_next = 1'b1;
                  state_next = st_idle;
               end
            end
         end
         st_poll: begin
            if (bus_done) begin
               poll_word_next = poll_masked;
               first_next = 1'b0;
               bus_start = 1'b1;
               if (!first_reg) begin
                  tb1_tog_next = tb1_changed;
                  tb2_tog_next = tb2_changed;
               end
               if (!first_reg && (poll_match || toggle_stopped)) begin
                  // poll bit may settle ahead of the rest: fetch once more
                  state_next = st_final;
               end else if (bus_rdata[PB_ABORT]) begin
                  bus_start = 1'b0;
                  fail_abort_next = 1'b1;
                  done_next = 1'b1;
                  state_next = st_idle;
               end else if (bus_rdata[PB_TIMEOUT] && timeout_seen_reg) begin
                  bus_start = 1'b0;
                  fail_timeout_next = 1'b1;
                  done_next = 1'b1;
                  state_next = st_idle;
               end else if (bus_rdata[PB_TIMEOUT]) begin
                  // recheck once, the poll bit may move with the timeout bit
                  timeout_seen_next = 1'b1;
               end
            end
         end
         st_final: begin
            if (bus_done) begin
               data_word_next = bus_rdata;
               done_next = 1'b1;
               state_next = st_idle;
            end
         end
         default: begin
            state_next = st_idle;
         end
      endcase
   end

   // register read mux, data one cycle after the strobe
   always_comb begin
      sw_rdata_next = 32'h0000_0000;
      if (sw_read) begin
         unique case (sw_addr)
            OFF_CMD_ADDR: sw_rdata_next = 32'(cmd_addr_reg);
            OFF_CMD_DATA: sw_rdata_next = 32'(cmd_data_reg);
            OFF_POLL_ADDR: sw_rdata_next = 32'(poll_addr_reg);
            OFF_POLL_CFG: sw_rdata_next = 32'(expect_reg);
            OFF_STATE: begin
               sw_rdata_next[ST_BUSY] = busy;
               sw_rdata_next[ST_DONE] = done_reg;
               sw_rdata_next[ST_FAIL_TIMEOUT] = fail_timeout_reg;
               sw_rdata_next[ST_FAIL_ABORT] = fail_abort_reg;
               sw_rdata_next[ST_TB1_TOGGLED] = tb1_tog_reg;
               sw_rdata_next[ST_TB2_TOGGLED] = tb2_tog_reg;
               sw_rdata_next[ST_ERASE_TIMER] = poll_word_reg[PB_ERASE_TIMER];
               sw_rdata_next[ST_SR_READY] = sr_word_reg[SR_READY];
               sw_rdata_next[ST_PIN_READY] = ready_busy_n;
            end
            OFF_SR_WORD: sw_rdata_next = 32'(sr_word_reg);
            OFF_POLL_WORD: sw_rdata_next = 32'(poll_word_reg);
            OFF_DATA_WORD: sw_rdata_next = 32'(data_word_reg);
            default: sw_rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= st_idle;
         op_reg <= 3'h0;
         wait_ready_reg <= 1'b0;
         toggle_done_reg <= 1'b0;
         sr_word_reg <= '0;
         poll_word_reg <= '0;
         data_word_reg <= '0;
         first_reg <= 1'b0;
         timeout_seen_reg <= 1'b0;
         done_reg <= 1'b0;
         fail_timeout_reg <= 1'b0;
         fail_abort_reg <= 1'b0;
         tb1_tog_reg <= 1'b0;
         tb2_tog_reg <= 1'b0;
         sw_rdata <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         wait_ready_reg <= wait_ready_next;
         toggle_done_reg <= toggle_done_next;
         sr_word_reg <= sr_word_next;
         poll_word_reg <= poll_word_next;
         data_word_reg <= data_word_next;
         first_reg <= first_next;
         timeout_seen_reg <= timeout_seen_next;
         done_reg <= done_next;
         fail_timeout_reg <= fail_timeout_next;
         fail_abort_reg <= fail_abort_next;
         tb1_tog_reg <= tb1_tog_next;
         tb2_tog_reg <= tb2_tog_next;
         sw_rdata <= sw_rdata_next;
      end
   end

   // set-up registers, frozen while an operation runs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_addr_reg <= '0;
         cmd_data_reg <= '0;
         poll_addr_reg <= '0;
         expect_reg <= '0;
      end else begin
         if (wr_cmd_addr && !busy) cmd_addr_reg <= sw_wdata[ADDR_W-1:0];
         if (wr_cmd_data && !busy) cmd_data_reg <= sw_wdata[DATA_W-1:0];
         if (wr_poll_addr && !busy) poll_addr_reg <= sw_wdata[ADDR_W-1:0];
         if (wr_poll_cfg && !busy) expect_reg <= sw_wdata[DATA_W-1:0];
      end
   end

   flash_bus_cycle bus_cycle (
      .clk(clk),
      .rst_b(rst_b),
      .start(bus_start),
      .write(bus_write),
      .addr(bus_addr),
      .wdata(bus_wdata),
      .done(bus_done),
      .rdata(bus_rdata),
      .flash_addr(flash_addr),
      .dq_out(dq_out),
      .dq_oe(dq_oe),
      .dq_in(dq_in),
      .chip_select_n(chip_select_n),
      .output_strobe_n(output_strobe_n),
      .write_strobe_n(write_strobe_n)
   );
endmodule // flash_status_monitor
`default_nettype wire

// >>> verification/flash_status_monitor_sva.sv
// port assertions for the flash status host controller
`default_nettype none
module flash_status_monitor_sva (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [flash_host_pkg::REG_AW-1:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_write,
   input wire logic sw_read,
   input wire logic [31:0] sw_rdata,
   input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
   input wire logic dq_oe,
   input wire logic chip_select_n,
   input wire logic output_strobe_n,
   input wire logic write_strobe_n
);
   import flash_host_pkg::*;
   logic [ADDR_W-1:0] poll_addr_reg;
   logic [2:0] op_reg;
   logic ctrl_wr;
   assign ctrl_wr = sw_write && sw_addr == OFF_CTRL;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         poll_addr_reg <= '0;
         op_reg <= 3'h0;
      end else begin
         if (sw_write && sw_addr == OFF_POLL_ADDR) poll_addr_reg <= sw_wdata[ADDR_W-1:0];
         if (ctrl_wr) op_reg <= sw_wdata[2:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_cmd_write;
      !write_strobe_n && !chip_select_n && dq_oe ##1 write_strobe_n && chip_select_n;
   endsequence
   sequence s_word_read;
      !output_strobe_n [*2] ##1 output_strobe_n;
   endsequence
   a_status_walk: assert property (ctrl_wr && sw_wdata[2:0] == OP_STATUS |=> s_cmd_write ##1 s_word_read)
      else $error("status op did not write the command then read once");
   a_read_width: assert property ($fell(output_strobe_n) |-> s_word_read)
      else $error("read strobe width wrong");
   a_write_width: assert property ($fell(write_strobe_n) |-> s_cmd_write)
      else $error("write strobe width or data enable wrong");
   a_read_bus: assert property (!output_strobe_n |-> !chip_select_n && !dq_oe && write_strobe_n)
      else $error("read cycle with bad strobes or driven bus");
   a_addr_stable: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(flash_addr))
      else $error("address moved inside a bus cycle");
   a_poll_addr: assert property (op_reg == OP_POLL && !output_strobe_n |-> flash_addr == poll_addr_reg)
      else $error("poll read away from poll address");
   a_sr_masked: assert property ($past(sw_read && sw_addr == OFF_SR_WORD) |-> (sw_rdata & ~{16'h0, SR_MASK}) == '0)
      else $error("status word reserved bits not masked");
   a_poll_masked: assert property ($past(sw_read && sw_addr == OFF_POLL_WORD) |-> (sw_rdata & ~{16'h0, POLL_MASK}) == '0)
      else $error("polling word reserved bits not masked");
endmodule // flash_status_monitor_sva
`default_nettype wire

// >>> verification/flash_device_model.sv
// behavioural flash device: status word, polling word, one array word
`default_nettype none
module flash_device_model #(
   parameter int BUSY_READS = 4
) (
   input wire logic rst_b,
   input wire logic [25:0] flash_addr,
   input wire logic [15:0] dq_out,
   input wire logic chip_select_n,
   input wire logic output_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [1:0] inject,
   output logic [15:0] dq_in,
   output logic ready_busy_n
);
   logic [7:0] sr, latch;
   logic [15:0] arr, noise, word;
   logic [25:0] arr_a;
   logic overlay, pend, t1, d7;
   int busy;
   assign word = overlay ? {noise[15:8], latch[7:1], noise[0]}
      : busy != 0 ? {noise[15:8], ~d7, t1, inject == 2'd1, noise[4], 2'b00, inject == 2'd2, noise[0]}
      : flash_addr == arr_a ? arr : 16'hffff;
   // a released bus shows the inverse, never the last word
   assign dq_in = !chip_select_n && !output_strobe_n ? word : ~word;
   assign ready_busy_n = busy == 0;
   always @(posedge write_strobe_n or negedge rst_b) begin
      if (!rst_b) begin
         sr = 8'h80;
         latch = 8'h00;
         noise = 16'hace1;
         overlay = 1'b0;
         pend = 1'b0;
         t1 = 1'b0;
         d7 = 1'b0;
         busy = 0;
         arr = 16'hffff;
         arr_a = '0;
      end else if (pend && sr[6]) begin
         // the whole array counts as the erase-paused sector
         sr[4] = 1'b1;
         pend = 1'b0;
      end else if (pend) begin
         // a locked word keeps its erased value
         arr = inject == 2'd3 ? 16'hffff : dq_out;
         d7 = dq_out[7];
         arr_a = flash_addr;
         busy = BUSY_READS;
         sr[7] = 1'b0;
         pend = 1'b0;
      end else if (dq_out == 16'h0070) begin
         latch = sr;
         overlay = 1'b1;
      end else if (busy == 0) begin
         case (dq_out)
            16'h00a0: pend = 1'b1;
            16'h0071: sr = sr & 8'hc5;
            16'h00f0: if (!sr[3]) sr = sr & 8'hcc;
            16'h00b0: sr[6] = 1'b1;
            16'h0030: sr[6] = 1'b0;
            16'h0051: sr[2] = 1'b1;
            16'h0050: sr[2] = 1'b0;
            default: ;
         endcase
      end
   end
   always @(posedge output_strobe_n) begin
      if (rst_b) begin
         noise = {noise[14:0], noise[15] ^ noise[13]};
         overlay = 1'b0;
         if (busy != 0) begin
            t1 = ~t1;
            busy = busy - 1;
            if (busy == 0) sr = sr | {1'b1, 2'b00, inject[0], inject == 2'd2, 1'b0, inject == 2'd3, 1'b0};
         end
      end
   end
endmodule // flash_device_model
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the flash status host controller
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_host_pkg::*;
   logic clk, rst_b, sw_write, sw_read, dq_oe, chip_select_n, output_strobe_n, write_strobe_n, ready_busy_n;
   logic [REG_AW-1:0] sw_addr;
   logic [31:0] sw_wdata, sw_rdata, rd;
   logic [ADDR_W-1:0] flash_addr;
   logic [DATA_W-1:0] dq_out, dq_in;
   logic [1:0] inject;
   int n_errors, n_compared;
   flash_status_monitor flash_status_monitor_i (.clk(clk), .rst_b(rst_b), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata),
      .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .chip_select_n(chip_select_n),
      .output_strobe_n(output_strobe_n), .write_strobe_n(write_strobe_n), .ready_busy_n(ready_busy_n));
   flash_device_model flash_device_model_i (.rst_b(rst_b), .flash_addr(flash_addr), .dq_out(dq_out),
      .chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n), .write_strobe_n(write_strobe_n),
      .inject(inject), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
   task automatic end_sim();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      sw_write <= 1'b1;
      sw_addr <= a;
      sw_wdata <= d;
      @(posedge clk);
      sw_write <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      sw_read <= 1'b1;
      sw_addr <= a;
      @(posedge clk);
      sw_read <= 1'b0;
      #1 rd = sw_rdata;
   endtask
   task automatic go(input logic [4:0] ctl);
      int k;
      k = 0;
      wr(OFF_CTRL, {27'h0, ctl});
      rd = 32'h1;
      while (rd[ST_BUSY] !== 1'b0 && k < 200) begin
         rdr(OFF_STATE);
         k++;
      end
      cmp({31'h0, rd[ST_BUSY]}, 32'h0);
   endtask
   task automatic op(input logic [25:0] a, input logic [15:0] d, input logic [4:0] ctl);
      wr(OFF_CMD_ADDR, {6'h0, a});
      wr(OFF_CMD_DATA, {16'h0, d});
      go(ctl);
   endtask
   task automatic status(input logic [31:0] exp);
      op(26'h0, 16'h0070, 5'h0a);
      rdr(OFF_SR_WORD);
      cmp(rd, exp);
   endtask
   task automatic prog(input logic [15:0] d);
      op(26'h555, 16'h00a0, 5'h01);
      op(26'h12345, d, 5'h01);
      wr(OFF_POLL_ADDR, 32'h12345);
      wr(OFF_POLL_CFG, {16'h0, d});
      go(5'h03);
   endtask
   task automatic t_reset();
      rdr(OFF_STATE);
      cmp(rd, 32'h100);
      rdr(OFF_SR_WORD);
      cmp(rd, 32'h0);
      rdr(8'h24);
      cmp(rd, 32'h0);
      rdr(OFF_CTRL);
      cmp(rd, 32'h0);
      status(32'h80);
   endtask
   task automatic t_cmds();
      logic [15:0] code [4] = '{16'h00b0, 16'h0030, 16'h0051, 16'h0050};
      logic [31:0] exp [4] = '{32'hc0, 32'h80, 32'h84, 32'h80};
      for (int i = 0; i < 4; i++) begin
         op(26'h0, code[i], 5'h01);
         status(exp[i]);
      end
   endtask
   task automatic t_prog();
      prog(16'h5abc);
      rdr(OFF_DATA_WORD);
      cmp(rd, 32'h5abc);
      rdr(OFF_STATE);
      cmp(rd & 32'h112, 32'h112);
      status(32'h80);
   endtask
   task automatic t_fail(input logic [1:0] inj, input int bitn, input logic [31:0] e1, input logic [31:0] e2);
      inject <= inj;
      prog(16'h1234);
      rdr(OFF_STATE);
      cmp({31'h0, rd[bitn]}, 32'h1);
      status(e1);
      op(26'h0, 16'h00f0, 5'h01);
      status(e2);
      inject <= 2'd0;
   endtask
   task automatic t_lock();
      inject <= 2'd3;
      prog(16'h12b4);
      inject <= 2'd0;
      rdr(OFF_DATA_WORD);
      cmp(rd, 32'hffff);
      status(32'h92);
      op(26'h0, 16'h00f0, 5'h01);
      op(26'h0, 16'h00b0, 5'h01);
      prog(16'h12b4);
      status(32'hd0);
   endtask
   task automatic t_warm();
      op(26'h0, 16'h00b0, 5'h01);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      status(32'h80);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #2000000;
      n_errors++;
      $display("mismatch at %0t: watchdog ran out", $time);
      end_sim();
   end
   initial begin
      rst_b = 1'b0;
      sw_write = 1'b0;
      sw_read = 1'b0;
      sw_addr = '0;
      sw_wdata = '0;
      inject = 2'd0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_cmds();
      t_prog();
      t_fail(2'd1, ST_FAIL_TIMEOUT, 32'h90, 32'h80);
      t_fail(2'd2, ST_FAIL_ABORT, 32'h88, 32'h88);
      op(26'h0, 16'h0071, 5'h01);
      status(32'h80);
      t_lock();
      t_warm();
      end_sim();
   end
endmodule // testbench
bind flash_status_monitor flash_status_monitor_sva flash_status_monitor_sva_i (.clk(clk), .rst_b(rst_b),
   .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata),
   .flash_addr(flash_addr), .dq_oe(dq_oe), .chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
   .write_strobe_n(write_strobe_n));
`default_nettype wire
